// ==== arb_budget_map.svh ====
`ifndef ARB_BUDGET_MAP_SVH
`define ARB_BUDGET_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_W 12
`define OFF_ARB_WORD1 12'h224
`define OFF_ARB_WORD2 12'h228
`define OFF_ARB_WORD3 12'h22c
`define OFF_CAP_HDR 12'h280
`define OFF_DATA_SEL 12'h284
`define OFF_DATA_WIN 12'h288
`define OFF_UNLOCK_CTRL 12'h290
`define OFF_VALUE_BASE 12'h300
`define OFF_VALUE_LAST 12'h31c

// ----------------------------------------
// field layout
// ----------------------------------------
`define CAP_ID_LSB 0
`define CAP_ID_W 16
`define CAP_REV_LSB 16
`define CAP_REV_W 4
`define CAP_NEXT_LSB 20
`define CAP_NEXT_W 12
`define SEL_W 8
`define UNLOCK_BIT 0
`define SLOT_W 4
`define SLOTS_PER_WORD 8

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define ARB_WORD_RST 32'h0
`define CAP_HDR_RST 32'h0
`define SEL_RST 8'h0
`define VALUE_RST 32'h0
`define VALUE_COUNT 8
`define VALUE_SEL_MAX 8'h07
`define SLOT_COUNT 24
`define SLOT_FIRST 5'h08
`define PORT_UPSTREAM 4'h0
`define PORT_DOWN_LOW 4'h2
`define PORT_DOWN_HIGH 4'h5
`define PORT_COUNT 6

`endif

// ==== arb_budget_pkg.sv ====
`include "arb_budget_map.svh"

package arb_budget_pkg;

  typedef logic [`SLOT_W-1:0] slot_code_t;
  typedef logic [31:0] word_t;
  typedef logic [`ADDR_W-1:0] addr_t;

  typedef enum {
    SEL_NONE,
    SEL_ARB1,
    SEL_ARB2,
    SEL_ARB3,
    SEL_CAP,
    SEL_DSEL,
    SEL_DWIN,
    SEL_UNLOCK,
    SEL_VALUE
  } reg_sel_e;

endpackage

// ==== arb_slot_check.sv ====
`timescale 1ns/10ps
`include "arb_budget_map.svh"

module arb_slot_check
  import arb_budget_pkg::*;
(
  // slot under test
  input wire slot_code_t code_i,
  // port context
  input wire slot_code_t egress_port_i,
  input wire logic [`PORT_COUNT-1:0] port_present_i,
  // verdict
  output logic ok_o
);

  logic legal;

  always_comb begin
    legal = (code_i == `PORT_UPSTREAM) ||
            ((code_i >= `PORT_DOWN_LOW) && (code_i <= `PORT_DOWN_HIGH));
    // reserved codes and the egress port are skipped like absent ports
    ok_o = legal && (code_i != egress_port_i) && port_present_i[code_i[2:0]];
  end

endmodule // arb_slot_check

// ==== budget_value_store.sv ====
`timescale 1ns/10ps
`include "arb_budget_map.svh"

module budget_value_store
  import arb_budget_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // software write
  input wire logic wr_i,
  input wire logic [2:0] idx_i,
  input wire word_t wdata_i,
  input wire logic unlock_i,
  // loader write
  input wire logic ee_wr_i,
  input wire logic [2:0] ee_idx_i,
  input wire word_t ee_wdata_i,
  // window
  input wire logic [`SEL_W-1:0] sel_i,
  output word_t window_o
);

  word_t mem_r [`VALUE_COUNT];
  word_t mem_nxt [`VALUE_COUNT];

  always_comb begin
    for (int i = 0; i < `VALUE_COUNT; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (wr_i && unlock_i) begin
      mem_nxt[idx_i] = wdata_i;
    end
    // loader wins over a clashing software write
    if (ee_wr_i) begin
      mem_nxt[ee_idx_i] = ee_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < `VALUE_COUNT; i++) begin
      if (!nrst_i) begin
        mem_r[i] <= `VALUE_RST;
      end else begin
        mem_r[i] <= mem_nxt[i];
      end
    end
  end

  always_comb begin
    window_o = (sel_i <= `VALUE_SEL_MAX) ? mem_r[sel_i[2:0]] : '0;
  end

  property p_locked_hold;
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_i && !unlock_i && !ee_wr_i) |=> (mem_r[$past(idx_i)] == $past(mem_r[idx_i]));
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("locked value changed");

  property p_unlocked_take;
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_i && unlock_i && !ee_wr_i) |=> (mem_r[$past(idx_i)] == $past(wdata_i));
  endproperty
  a_unlocked_take: assert property (p_unlocked_take) else $error("unlocked write lost");

endmodule // budget_value_store

// ==== arb_table_power_budget_regs.sv ====
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "arb_budget_map.svh"

module arb_table_power_budget_regs
  import arb_budget_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire addr_t addr_i,
  input wire word_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output word_t rdata_o,
  // serial eeprom loader
  input wire logic ee_wr_i,
  input wire addr_t ee_addr_i,
  input wire word_t ee_wdata_i,
  // arbiter side
  input wire slot_code_t egress_port_i,
  input wire logic [`PORT_COUNT-1:0] port_present_i,
  input wire logic arb_adv_i,
  output logic [4:0] arb_phase_o,
  output slot_code_t arb_port_o,
  output logic arb_valid_o
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic reg_sel_e decode(input addr_t a);
    reg_sel_e s;
    s = SEL_NONE;
    if (a == `OFF_ARB_WORD1) s = SEL_ARB1;
    else if (a == `OFF_ARB_WORD2) s = SEL_ARB2;
    else if (a == `OFF_ARB_WORD3) s = SEL_ARB3;
    else if (a == `OFF_CAP_HDR) s = SEL_CAP;
    else if (a == `OFF_DATA_SEL) s = SEL_DSEL;
    else if (a == `OFF_DATA_WIN) s = SEL_DWIN;
    else if (a == `OFF_UNLOCK_CTRL) s = SEL_UNLOCK;
    else if (a >= `OFF_VALUE_BASE && a <= `OFF_VALUE_LAST && a[1:0] == 2'b00) s = SEL_VALUE;
    return s;
  endfunction

  reg_sel_e bus_sel;
  reg_sel_e ee_sel;

  always_comb begin
    bus_sel = decode(addr_i);
    ee_sel = decode(ee_addr_i);
  end

  // ----------------------------------------
  // register state
  // ----------------------------------------
  word_t arb_word_r [3];
  word_t arb_word_nxt [3];
  word_t cap_hdr_r;
  word_t cap_hdr_nxt;
  logic [`SEL_W-1:0] value_sel_r;
  logic [`SEL_W-1:0] value_sel_nxt;
  logic budget_value_unlock_r;
  logic budget_value_unlock_nxt;
  word_t rdata_r;
  word_t rdata_nxt;
  word_t window;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      arb_word_nxt[i] = arb_word_r[i];
    end
    cap_hdr_nxt = cap_hdr_r;
    value_sel_nxt = value_sel_r;
    budget_value_unlock_nxt = budget_value_unlock_r;
    if (wr_i) begin
      unique case (bus_sel)
        SEL_ARB1: arb_word_nxt[0] = wdata_i;
        SEL_ARB2: arb_word_nxt[1] = wdata_i;
        SEL_ARB3: arb_word_nxt[2] = wdata_i;
        SEL_DSEL: value_sel_nxt = wdata_i[`SEL_W-1:0];
        SEL_UNLOCK: budget_value_unlock_nxt = wdata_i[`UNLOCK_BIT];
        SEL_CAP, SEL_DWIN, SEL_VALUE, SEL_NONE: ;
      endcase
    end
    if (ee_wr_i && ee_sel == SEL_CAP) begin
      cap_hdr_nxt = ee_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 3; i++) begin
        arb_word_r[i] <= `ARB_WORD_RST;
      end
      cap_hdr_r <= `CAP_HDR_RST;
      value_sel_r <= `SEL_RST;
      budget_value_unlock_r <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        arb_word_r[i] <= arb_word_nxt[i];
      end
      cap_hdr_r <= cap_hdr_nxt;
      value_sel_r <= value_sel_nxt;
      budget_value_unlock_r <= budget_value_unlock_nxt;
    end
  end

  // ----------------------------------------
  // budget value entries
  // ----------------------------------------
  // window resolved against the 0-7 limit
  budget_value_store u_values (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_i(wr_i && bus_sel == SEL_VALUE),
    .idx_i(addr_i[4:2]),
    .wdata_i(wdata_i),
    .unlock_i(budget_value_unlock_r),
    .ee_wr_i(ee_wr_i && ee_sel == SEL_VALUE),
    .ee_idx_i(ee_addr_i[4:2]),
    .ee_wdata_i(ee_wdata_i),
    .sel_i(value_sel_r),
    .window_o(window)
  );

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // data stands only in the cycle after the strobe; reads change no state
  always_comb begin
    rdata_nxt = '0;
    if (rd_i) begin
      unique case (bus_sel)
        SEL_ARB1: rdata_nxt = arb_word_r[0];
        SEL_ARB2: rdata_nxt = arb_word_r[1];
        SEL_ARB3: rdata_nxt = arb_word_r[2];
        SEL_CAP: rdata_nxt = cap_hdr_r;
        SEL_DSEL: rdata_nxt = {24'h0, value_sel_r};
        SEL_DWIN: rdata_nxt = window;
        SEL_UNLOCK: rdata_nxt = {31'h0, budget_value_unlock_r};
        SEL_VALUE: rdata_nxt = '0;
        SEL_NONE: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

  // ----------------------------------------
  // arbitration slots
  // ----------------------------------------
  slot_code_t slot_code [`SLOT_COUNT];
  logic [`SLOT_COUNT-1:0] slot_ok;

  // slot n sits in nibble n mod 8
  // legal port codes decoded per slot
  for (genvar g = 0; g < `SLOT_COUNT; g++) begin : g_slot
    assign slot_code[g] = arb_word_r[g / 8][(g % 8) * 4 +: 4];
    arb_slot_check u_chk (
      .code_i(slot_code[g]),
      .egress_port_i(egress_port_i),
      .port_present_i(port_present_i),
      .ok_o(slot_ok[g])
    );
  end

  logic [4:0] phase_r;
  logic [4:0] phase_nxt;
  logic [4:0] serve_idx;
  logic serve_found;

  // skip invalid slots in the same cycle
  always_comb begin
    int cand;
    cand = 0;
    serve_idx = phase_r;
    serve_found = 1'b0;
    for (int k = 0; k < `SLOT_COUNT; k++) begin
      cand = (int'(phase_r) + k) % `SLOT_COUNT;
      if (!serve_found && slot_ok[cand]) begin
        serve_idx = 5'(cand);
        serve_found = 1'b1;
      end
    end
  end

  always_comb begin
    phase_nxt = phase_r;
    if (arb_adv_i && serve_found) begin
      phase_nxt = (serve_idx == 5'(`SLOT_COUNT - 1)) ? 5'h0 : serve_idx + 5'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      phase_r <= 5'h0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // serve the port named in the slot
  assign arb_phase_o = serve_idx + `SLOT_FIRST;
  assign arb_port_o = slot_code[serve_idx];
  assign arb_valid_o = serve_found;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_word1;
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_i && addr_i == `OFF_ARB_WORD1) |=> (arb_word_r[0] == $past(wdata_i));
  endproperty
  a_word1: assert property (p_word1) else $error("word one not written");

  property p_word2;
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_i && addr_i == `OFF_ARB_WORD2) |=> (arb_word_r[1] == $past(wdata_i));
  endproperty
  a_word2: assert property (p_word2) else $error("word two not written");

  property p_rdata_idle;
    @(posedge clk_i) disable iff (!nrst_i)
    !rd_i |=> (rdata_o == 32'h0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing");

  property p_word3_read;
    @(posedge clk_i) disable iff (!nrst_i)
    (rd_i && addr_i == `OFF_ARB_WORD3 && !wr_i) |=> (rdata_o == $past(arb_word_r[2]));
  endproperty
  a_word3_read: assert property (p_word3_read) else $error("word three read wrong");

  property p_port_from_table;
    @(posedge clk_i) disable iff (!nrst_i)
    arb_valid_o |-> (arb_port_o ==
      arb_word_r[arb_phase_o[4:3] - 2'h1][{arb_phase_o[2:0], 2'b00} +: 4]);
  endproperty
  a_port_from_table: assert property (p_port_from_table) else $error("port not from slot");

  property p_legal_code;
    @(posedge clk_i) disable iff (!nrst_i)
    arb_valid_o |-> ((arb_port_o == 4'h0 || (arb_port_o >= 4'h2 && arb_port_o <= 4'h5))
      && arb_port_o != egress_port_i);
  endproperty
  a_legal_code: assert property (p_legal_code) else $error("invalid port served");

  property p_no_stall;
    @(posedge clk_i) disable iff (!nrst_i)
    (arb_adv_i && arb_valid_o && !wr_i) |=> arb_valid_o;
  endproperty
  a_no_stall: assert property (p_no_stall) else $error("arbiter lost its slot");

  property p_cap_locked;
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_i && addr_i == `OFF_CAP_HDR && !ee_wr_i) |=> $stable(cap_hdr_r);
  endproperty
  a_cap_locked: assert property (p_cap_locked) else $error("header took a bus write");

  property p_cap_load;
    @(posedge clk_i) disable iff (!nrst_i)
    (ee_wr_i && ee_addr_i == `OFF_CAP_HDR) |=>
      (cap_hdr_r[`CAP_REV_LSB +: `CAP_REV_W] == $past(ee_wdata_i[19:16]));
  endproperty
  a_cap_load: assert property (p_cap_load) else $error("header load lost");

  property p_sel_write;
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_i && addr_i == `OFF_DATA_SEL) |=> (value_sel_r == $past(wdata_i[7:0]));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("selector not written");

  property p_window_zero;
    @(posedge clk_i) disable iff (!nrst_i)
    (rd_i && addr_i == `OFF_DATA_WIN && value_sel_r > 8'h07) |=> (rdata_o == 32'h0);
  endproperty
  a_window_zero: assert property (p_window_zero) else $error("window not zero");

  property p_sel_reserved;
    @(posedge clk_i) disable iff (!nrst_i)
    (rd_i && addr_i == `OFF_DATA_SEL) |=> (rdata_o[31:8] == 24'h0);
  endproperty
  a_sel_reserved: assert property (p_sel_reserved) else $error("reserved bits set");

endmodule // arb_table_power_budget_regs

// ==== tb.sv ====
`timescale 1ns/10ps
`include "arb_budget_map.svh"

module tb
  import arb_budget_pkg::*;
;
  logic clk_i, nrst_i, wr_i, rd_i, ee_wr_i, arb_adv_i, arb_valid_o;
  addr_t addr_i, ee_addr_i;
  word_t wdata_i, ee_wdata_i, rdata_o, v;
  slot_code_t egress_port_i, arb_port_o;
  logic [`PORT_COUNT-1:0] port_present_i;
  logic [4:0] arb_phase_o;
  int err_count, checks_done, idx;
  word_t tbl [3];
  word_t vals [8];
  addr_t offs [7] = '{`OFF_ARB_WORD1, `OFF_ARB_WORD2, `OFF_ARB_WORD3, `OFF_CAP_HDR,
    `OFF_DATA_SEL, `OFF_DATA_WIN, `OFF_UNLOCK_CTRL};
  logic [7:0] sels [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h08, 8'h1f, 8'hff, 8'h00};

  arb_table_power_budget_regs arb_table_power_budget_regs_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .ee_wr_i(ee_wr_i), .ee_addr_i(ee_addr_i),
    .ee_wdata_i(ee_wdata_i), .egress_port_i(egress_port_i), .port_present_i(port_present_i),
    .arb_adv_i(arb_adv_i), .arb_phase_o(arb_phase_o), .arb_port_o(arb_port_o),
    .arb_valid_o(arb_valid_o));

  // ----------------------------------------
  // checking and expectations
  // ----------------------------------------
  task automatic chk(input string what, input word_t exp, input word_t got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic bit ok_code(input slot_code_t c);
    return c < 4'h6 && c != 4'h1 && c != egress_port_i && port_present_i[c[2:0]] === 1'b1;
  endfunction

  // first usable slot at or after a phase, 0 when none
  function automatic int nxt_ph(input int from);
    int p;
    for (int i = 0; i < 24; i++) begin
      p = 8 + (from - 8 + i) % 24;
      if (ok_code(tbl[(p - 8) / 8][(p % 8) * 4 +: 4])) return p;
    end
    return 0;
  endfunction

  function automatic word_t win_exp(input logic [7:0] s);
    return (s > `VALUE_SEL_MAX) ? 32'h0 : vals[s[2:0]];
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // bus, loader and arbiter drivers
  // ----------------------------------------
  task automatic wr(input addr_t a, input word_t d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input addr_t a, input word_t exp, input string what);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(what, exp, rdata_o);
  endtask

  task automatic ee(input addr_t a, input word_t d);
    @(posedge clk_i);
    ee_wr_i <= 1'b1;
    ee_addr_i <= a;
    ee_wdata_i <= d;
    @(posedge clk_i);
    ee_wr_i <= 1'b0;
  endtask

  // idx is the phase where the search starts, not the phase served
  task automatic arb_chk();
    int p;
    p = nxt_ph(idx);
    if (p == 0) chk("arb_valid", 32'h0, {31'h0, arb_valid_o});
    else chk("arb_slot", {22'h0, 1'b1, 5'(p), tbl[(p - 8) / 8][(p % 8) * 4 +: 4]},
      {22'h0, arb_valid_o, arb_phase_o, arb_port_o});
  endtask

  // advance held high for back-to-back periods
  task automatic run_arb(input int steps);
    int p;
    @(posedge clk_i);
    arb_adv_i <= 1'b1;
    for (int i = 0; i < steps; i++) begin
      @(posedge clk_i);
      if (i == steps - 1) arb_adv_i <= 1'b0;
      #1;
      p = nxt_ph(idx);
      // a taken advance restarts the search one past the slot served
      if (p != 0) idx = (p == 31) ? 8 : p + 1;
      arb_chk();
    end
  endtask

  task automatic load_tbl(input word_t a, input word_t b, input word_t c);
    tbl = '{a, b, c};
    for (int k = 0; k < 3; k++) wr(offs[k], tbl[k]);
    #1;
    arb_chk();
  endtask

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (6000) @(posedge clk_i);
    err_count++;
    close_out();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {nrst_i, wr_i, rd_i, ee_wr_i, arb_adv_i} = '0;
    {addr_i, ee_addr_i, wdata_i, ee_wdata_i} = '0;
    egress_port_i = 4'h4;
    port_present_i = '1;
    void'($urandom(32'h8ee6));
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    foreach (offs[i]) rd(offs[i], 32'h0, "reset_value");
    rd(12'h3fc, 32'h0, "unmapped");
    $display("test reset_values done");
    for (int k = 0; k < 9; k++) begin
      v = $urandom();
      wr(offs[k % 3], v);
      rd(offs[k % 3], v, "arb_word");
    end
    $display("test arb_words done");
    wr(`OFF_CAP_HDR, 32'hffffffff);
    rd(`OFF_CAP_HDR, 32'h0, "cap_hdr_bus");
    ee(`OFF_CAP_HDR, 32'h00010004);
    rd(`OFF_CAP_HDR, 32'h00010004, "cap_hdr_load");
    v = $urandom();
    ee(`OFF_CAP_HDR, v);
    rd(`OFF_CAP_HDR, v, "cap_hdr_link");
    wr(`OFF_DATA_SEL, 32'hffffffa5);
    rd(`OFF_DATA_SEL, 32'h000000a5, "data_sel");
    $display("test header_select done");
    foreach (vals[n]) vals[n] = 32'h0;
    wr(`OFF_VALUE_BASE, 32'h12345678);
    wr(`OFF_DATA_SEL, 32'h0);
    rd(`OFF_DATA_WIN, 32'h0, "locked_value");
    wr(`OFF_UNLOCK_CTRL, 32'h1);
    rd(`OFF_UNLOCK_CTRL, 32'h1, "unlock_bit");
    foreach (vals[n]) begin
      vals[n] = $urandom();
      wr(addr_t'(`OFF_VALUE_BASE + 4 * n), vals[n]);
    end
    rd(`OFF_VALUE_BASE, 32'h0, "value_direct");
    wr(`OFF_UNLOCK_CTRL, 32'h0);
    v = $urandom();
    ee(addr_t'(`OFF_VALUE_BASE + 12), v);
    vals[3] = v;
    wr(addr_t'(`OFF_VALUE_BASE + 12), ~v);
    wr(`OFF_DATA_WIN, $urandom());
    sels[11] = 8'($urandom());
    foreach (sels[i]) begin
      wr(`OFF_DATA_SEL, {24'h0, sels[i]});
      rd(`OFF_DATA_WIN, win_exp(sels[i]), "data_window");
      rd(`OFF_DATA_WIN, win_exp(sels[i]), "window_again");
    end
    $display("test data_window done");
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(`OFF_ARB_WORD1, 32'h0, "second_reset");
    idx = 8;
    @(posedge clk_i);
    port_present_i <= 6'b100101;
    load_tbl(32'h66605142, 32'h33333333, 32'h33333333);
    run_arb(5);
    @(posedge clk_i);
    port_present_i <= '0;
    #1;
    arb_chk();
    run_arb(2);
    for (int r = 0; r < 4; r++) begin
      @(posedge clk_i);
      port_present_i <= 6'($urandom());
      egress_port_i <= 4'(2 + $urandom_range(3));
      load_tbl($urandom() & 32'h77777777, $urandom() & 32'h77777777, $urandom());
      run_arb(6);
    end
    $display("test arbiter done");
    close_out();
  end
endmodule // tb
